/* logic/iod_device.sv */
/*
  i/o space decoder: register file of the standard i/o window, the
  extended peripheral slots, bit operations and write-one-clear flags.
  assumes: core end on the same clock issues one-cycle req pulses;
  the event inputs come from peripheral logic on the same clock.
*/
`timescale 1ns/100ps
`include "iod_params.svh"
module iod_device
  import iod_pkg::*;
#(
  parameter int IO_REGS = 64
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  iod_if.dev                             link,
  input  wire logic [7:0]                flag_set,
  input  wire logic                      twi_int_set,
  input  wire logic                      serial_txc_set,
  output logic      [7:0]                io_flags,
  output logic      [8*`IOD_SLOTS-1:0]   ext_view
);

  // ==========================================================
  // storage
  logic [7:0] io_ff  [IO_REGS];
  logic [7:0] ext_ff [`IOD_SLOTS];
  logic       ack_ff;
  logic [7:0] rdata_ff;
  logic       bit_val_ff;
  logic       skip_ff;
  logic       err_ff;

  // ==========================================================
  // decode
  logic       io_hit;
  logic       ext_hit;
  logic       bad;
  logic [5:0] io_idx;
  logic [3:0] slot;
  logic       is_write;
  logic       is_bit;
  logic [7:0] io_old;
  logic [7:0] io_w1c;
  logic [7:0] io_merged;
  logic [7:0] io_new;
  logic       io_we;
  logic [7:0] ext_old;
  iod_mask_s  ext_m;
  logic [7:0] ext_new;
  logic       ext_we;
  logic [7:0] rd;

  always_comb begin
    io_hit  = 1'b0;
    ext_hit = 1'b0;
    bad     = 1'b0;
    io_idx  = 6'h00;
    slot    = `IOD_SLOT_NONE;
    case (link.op)
      port_in_op, port_out_op: begin
        if (link.addr <= `IOD_PORT_TOP) begin
          io_hit = 1'b1;
          io_idx = link.addr[5:0];
        end else begin
          bad = 1'b1;
        end
      end
      bit_set_op, bit_clear_op, skip_if_bit_set_op, skip_if_bit_clear_op: begin
        // bit ops limited to low window
        if (link.addr <= `IOD_BIT_TOP) begin
          io_hit = 1'b1;
          io_idx = link.addr[5:0];
        end else begin
          bad = 1'b1;
        end
      end
      memory_read_op, memory_write_op: begin
        if (link.addr < `IOD_DATA_OFS) begin
          // below the window lies the core's own register file
          bad = 1'b1;
        end else if (link.addr < `IOD_EXT_BASE) begin
          io_hit = 1'b1;
          io_idx = 6'(link.addr - `IOD_DATA_OFS);
        end else begin
          slot = iod_ext_slot(link.addr);
          if (slot == `IOD_SLOT_NONE) begin
            bad = 1'b1;
          end else begin
            ext_hit = 1'b1;
          end
        end
      end
      default: begin
        bad = 1'b1;
      end
    endcase
  end

  assign is_write = (link.op == port_out_op) || (link.op == memory_write_op);
  assign is_bit   = (link.op == bit_set_op) || (link.op == bit_clear_op);
  assign io_old   = io_ff[io_idx];
  assign io_w1c   = (io_idx == `IOD_FLAG_IO) ? 8'hFF : 8'h00;

  // ==========================================================
  // standard window writes
  iod_bit_merge u_merge (
    .old_val  (io_old),
    .bit_sel  (link.bit_sel),
    .set      (link.op == bit_set_op),
    .w1c_mask (io_w1c),
    .new_val  (io_merged)
  );

  always_comb begin
    if (is_bit) begin
      io_new = io_merged;
    end else begin
      // ones clear flags, zeros keep them
      io_new = (io_old & io_w1c & ~link.wdata) | (link.wdata & ~io_w1c);
    end
  end

  assign io_we = link.req && io_hit && (is_write || is_bit);

  // ==========================================================
  // extended slot writes
  assign ext_old = ext_ff[slot[3:0] < 4'(`IOD_SLOTS) ? slot : 4'h0];
  assign ext_m   = iod_ext_mask(slot);

  // flag bits cleared only by a one
  assign ext_new = (ext_old & ~ext_m.wmask & ~(link.wdata & ext_m.w1c)) |
                   (link.wdata & ext_m.wmask);
  assign ext_we  = link.req && ext_hit && (link.op == memory_write_op);

  // ==========================================================
  // register storage, hardware events win over clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < IO_REGS; i++) begin
        io_ff[i] <= `IOD_RST_VAL;
      end
    end else begin
      for (int i = 0; i < IO_REGS; i++) begin
        if (i == int'(`IOD_FLAG_IO)) begin
          io_ff[i] <= ((io_we && io_idx == 6'(i)) ? io_new : io_ff[i]) | flag_set;
        end else if (io_we && io_idx == 6'(i)) begin
          io_ff[i] <= io_new;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `IOD_SLOTS; i++) begin
        ext_ff[i] <= `IOD_RST_VAL;
      end
    end else begin
      for (int i = 0; i < `IOD_SLOTS; i++) begin
        if (ext_we && slot == 4'(i)) begin
          ext_ff[i] <= ext_new;
        end
      end
      if (twi_int_set) begin
        ext_ff[`IOD_SLOT_TWI_CTRL][`IOD_TWI_INT_BIT] <= 1'b1;
      end
      if (serial_txc_set) begin
        ext_ff[`IOD_SLOT_SER_A][`IOD_SER_TXC_BIT] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // answer to the core
  always_comb begin
    if (io_hit) begin
      rd = io_old;
    end else if (ext_hit) begin
      rd = ext_old & ext_m.rmask;
    end else begin
      rd = 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_ff     <= 1'b0;
      rdata_ff   <= 8'h00;
      bit_val_ff <= 1'b0;
      skip_ff    <= 1'b0;
      err_ff     <= 1'b0;
    end else begin
      ack_ff <= link.req;
      err_ff <= link.req && bad;
      if (link.req) begin
        rdata_ff   <= rd;
        bit_val_ff <= rd[link.bit_sel];
        skip_ff    <= ((link.op == skip_if_bit_set_op) && rd[link.bit_sel]) ||
                      ((link.op == skip_if_bit_clear_op) && !rd[link.bit_sel]);
      end
    end
  end

  assign link.ack     = ack_ff;
  assign link.rdata   = rdata_ff;
  assign link.bit_val = bit_val_ff;
  assign link.skip    = skip_ff;
  assign link.err     = err_ff;

  // ==========================================================
  // user-side view of the stored state
  assign io_flags = io_ff[`IOD_FLAG_IO];
  always_comb begin
    for (int i = 0; i < `IOD_SLOTS; i++) begin
      ext_view[8*i +: 8] = ext_ff[i];
    end
  end

endmodule

/* inc/iod_params.svh */
/*
  constants of the i/o space decoder: address windows, register slots,
  field masks and the controller's own register map.
  assumes: included by its bare name from packages and modules.
*/
`ifndef IOD_PARAMS_SVH
`define IOD_PARAMS_SVH

// ==========================================================
// address windows
`define IOD_BIT_TOP      8'h1F
`define IOD_PORT_TOP     8'h3F
`define IOD_DATA_OFS     8'h20
`define IOD_EXT_BASE     8'h60
`define IOD_FLAG_IO      6'h16
`define IOD_RST_VAL      8'h00

// ==========================================================
// extended register addresses
`define IOD_A_TWI_SP     8'hB9
`define IOD_A_TWI_OA     8'hBA
`define IOD_A_TWI_DATA   8'hBB
`define IOD_A_TWI_CTRL   8'hBC
`define IOD_A_TWI_AMASK  8'hBD
`define IOD_A_SER_A      8'hC0
`define IOD_A_SER_B      8'hC1
`define IOD_A_SER_C      8'hC2
`define IOD_A_BAUD_L     8'hC4
`define IOD_A_BAUD_H     8'hC5
`define IOD_A_SER_DATA   8'hC6

// ==========================================================
// slot indices and per-slot masks: readable, writable, write-one-clear
`define IOD_SLOTS        11
`define IOD_SLOT_NONE    4'hF
`define IOD_SLOT_TWI_CTRL 4'h3
`define IOD_SLOT_SER_A   4'h5
`define IOD_TWI_INT_BIT  7
`define IOD_SER_TXC_BIT  6
`define IOD_M_TWI_SP     {8'hFB, 8'h03, 8'h00}
`define IOD_M_FULL       {8'hFF, 8'hFF, 8'h00}
`define IOD_M_TWI_CTRL   {8'hFD, 8'h75, 8'h80}
`define IOD_M_TWI_AMASK  {8'hFE, 8'hFE, 8'h00}
`define IOD_M_SER_A      {8'hFF, 8'h03, 8'h40}
`define IOD_M_SER_B      {8'hFF, 8'hFD, 8'h00}
`define IOD_M_BAUD_H     {8'h0F, 8'h0F, 8'h00}
`define IOD_M_NONE       {8'h00, 8'h00, 8'h00}

// ==========================================================
// controller registers on apb
`define IOD_R_CMD        12'h000
`define IOD_R_STATUS     12'h004
`define IOD_R_INT_ST     12'h008
`define IOD_R_INT_MASK   12'h00C
`define IOD_F_OP_LSB     0
`define IOD_F_ADDR_LSB   8
`define IOD_F_BIT_LSB    16
`define IOD_F_WDATA_LSB  24
`define IOD_INT_DONE     0
`define IOD_INT_ERR      1
`define IOD_INT_SKIP     2

`endif

/* inc/iod_pkg.sv */
/*
  types and shared decode functions of the i/o space decoder.
  assumes: iod_params.svh on the include path.
*/
`include "iod_params.svh"
package iod_pkg;

  // ==========================================================
  // operations issued by the core
  typedef enum logic [3:0] {
    op_none              = 4'h0,
    port_in_op           = 4'h1,
    port_out_op          = 4'h2,
    bit_set_op           = 4'h3,
    bit_clear_op         = 4'h4,
    skip_if_bit_set_op   = 4'h5,
    skip_if_bit_clear_op = 4'h6,
    memory_read_op       = 4'h7,
    memory_write_op      = 4'h8
  } iod_op_e;

  typedef struct packed {
    logic [7:0] rmask;
    logic [7:0] wmask;
    logic [7:0] w1c;
  } iod_mask_s;

  // ==========================================================
  // extended space decode, used by both ends
  function automatic logic [3:0] iod_ext_slot(input logic [7:0] a);
    case (a)
      `IOD_A_TWI_SP:    iod_ext_slot = 4'h0;
      `IOD_A_TWI_OA:    iod_ext_slot = 4'h1;
      `IOD_A_TWI_DATA:  iod_ext_slot = 4'h2;
      `IOD_A_TWI_CTRL:  iod_ext_slot = 4'h3;
      `IOD_A_TWI_AMASK: iod_ext_slot = 4'h4;
      `IOD_A_SER_A:     iod_ext_slot = 4'h5;
      `IOD_A_SER_B:     iod_ext_slot = 4'h6;
      `IOD_A_SER_C:     iod_ext_slot = 4'h7;
      `IOD_A_BAUD_L:    iod_ext_slot = 4'h8;
      `IOD_A_BAUD_H:    iod_ext_slot = 4'h9;
      `IOD_A_SER_DATA:  iod_ext_slot = 4'hA;
      default:          iod_ext_slot = `IOD_SLOT_NONE;
    endcase
  endfunction

  function automatic iod_mask_s iod_ext_mask(input logic [3:0] s);
    case (s)
      4'h0:    iod_ext_mask = `IOD_M_TWI_SP;
      4'h3:    iod_ext_mask = `IOD_M_TWI_CTRL;
      4'h4:    iod_ext_mask = `IOD_M_TWI_AMASK;
      4'h5:    iod_ext_mask = `IOD_M_SER_A;
      4'h6:    iod_ext_mask = `IOD_M_SER_B;
      4'h9:    iod_ext_mask = `IOD_M_BAUD_H;
      4'h1, 4'h2, 4'h7, 4'h8, 4'hA: iod_ext_mask = `IOD_M_FULL;
      default: iod_ext_mask = `IOD_M_NONE;
    endcase
  endfunction

  // data-space address that maps onto a register of the device
  function automatic logic iod_data_mapped(input logic [7:0] a);
    iod_data_mapped = (a >= `IOD_DATA_OFS) &&
                      ((a < `IOD_EXT_BASE) || (iod_ext_slot(a) != `IOD_SLOT_NONE));
  endfunction

endpackage

/* inc/iod_if.sv */
/*
  link between the processor core end and the i/o space decoder.
  assumes: both ends on one clock; req is a one-cycle pulse, ack follows.
*/
`timescale 1ns/100ps
interface iod_if;
  import iod_pkg::*;
  logic       req;
  iod_op_e    op;
  logic [7:0] addr;
  logic [2:0] bit_sel;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;
  logic       bit_val;
  logic       skip;
  logic       err;

  modport dev  (input req, op, addr, bit_sel, wdata,
                output ack, rdata, bit_val, skip, err);
  modport core (output req, op, addr, bit_sel, wdata,
                input ack, rdata, bit_val, skip, err);
endinterface

/* logic/iod_bit_merge.sv */
/*
  single-bit set/clear merge for bit-accessible registers.
  assumes: purely combinational, old value from the caller's flops.
*/
`timescale 1ns/100ps
module iod_bit_merge (
  input  wire logic [7:0] old_val,
  input  wire logic [2:0] bit_sel,
  input  wire logic       set,
  input  wire logic [7:0] w1c_mask,
  output logic      [7:0] new_val
);
  logic [7:0] one_hot;

  always_comb begin
    one_hot = 8'h01 << bit_sel;
    new_val = old_val;
    if (w1c_mask[bit_sel]) begin
      // a set on a flag writes a one, which clears it
      if (set) begin
        new_val = old_val & ~one_hot;
      end
    end else if (set) begin
      new_val = old_val | one_hot;
    end else begin
      new_val = old_val & ~one_hot;
    end
  end
endmodule

/* logic/iod_core.sv */
/*
  core end: takes one operation at a time from apb registers, issues it
  on the link and reports the answer, with a masked interrupt.
  assumes: apb master on pclk; device answers within a few cycles.
*/
`timescale 1ns/100ps
`include "iod_params.svh"
module iod_core
  import iod_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  iod_if.core              link
);

  // ==========================================================
  // state
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic        irq_ff;
  logic        busy_ff;
  logic        req_ff;
  iod_op_e     op_ff;
  logic [7:0]  addr_ff;
  logic [2:0]  bit_ff;
  logic [7:0]  wdata_ff;
  logic        st_err_ff;
  logic        st_bit_ff;
  logic        st_skip_ff;
  logic [7:0]  st_rdata_ff;
  logic [2:0]  int_st_ff;
  logic [2:0]  int_mask_ff;
  logic [2:0]  nxt_int_st;
  logic        acc;
  logic        fin;
  logic        start;
  logic        legal;
  logic        refuse;
  iod_op_e     cmd_op;
  logic [7:0]  cmd_addr;

  // extra wait state keeps every apb output on a flop
  assign acc = psel && penable && !pready_ff;
  assign fin = psel && penable && pready_ff;

  assign cmd_op   = iod_op_e'(pwdata[`IOD_F_OP_LSB +: 4]);
  assign cmd_addr = pwdata[`IOD_F_ADDR_LSB +: 8];
  assign start    = fin && pwrite && (paddr == `IOD_R_CMD) && !busy_ff;

  always_comb begin
    case (cmd_op)
      port_in_op, port_out_op: legal = (cmd_addr <= `IOD_PORT_TOP);
      bit_set_op, bit_clear_op, skip_if_bit_set_op, skip_if_bit_clear_op:
        legal = (cmd_addr <= `IOD_BIT_TOP);
      memory_read_op: legal = (cmd_addr >= `IOD_DATA_OFS);
      memory_write_op: legal = iod_data_mapped(cmd_addr);
      default: legal = 1'b0;
    endcase
  end

  assign refuse = start && !legal;

  // ==========================================================
  // apb slave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= acc;
      pslverr_ff <= acc && (paddr[11:4] != 8'h00 || paddr[1:0] != 2'b00);
      if (acc && !pwrite) begin
        case (paddr)
          `IOD_R_CMD:      prdata_ff <= {wdata_ff, 5'h00, bit_ff, addr_ff, 4'h0, op_ff};
          `IOD_R_STATUS:   prdata_ff <= {16'h0000, st_rdata_ff, 4'h0,
                                         st_skip_ff, st_bit_ff, st_err_ff, busy_ff};
          `IOD_R_INT_ST:   prdata_ff <= {29'h0, int_st_ff};
          `IOD_R_INT_MASK: prdata_ff <= {29'h0, int_mask_ff};
          default:         prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // command issue and answer capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff  <= 1'b0;
      req_ff   <= 1'b0;
      op_ff    <= op_none;
      addr_ff  <= 8'h00;
      bit_ff   <= 3'h0;
      wdata_ff <= 8'h00;
    end else begin
      req_ff <= start && legal;
      if (start) begin
        op_ff    <= cmd_op;
        addr_ff  <= cmd_addr;
        bit_ff   <= pwdata[`IOD_F_BIT_LSB +: 3];
        wdata_ff <= pwdata[`IOD_F_WDATA_LSB +: 8];
        busy_ff  <= legal;
      end else if (link.ack) begin
        busy_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_err_ff   <= 1'b0;
      st_bit_ff   <= 1'b0;
      st_skip_ff  <= 1'b0;
      st_rdata_ff <= 8'h00;
    end else if (refuse) begin
      st_err_ff <= 1'b1;
    end else if (link.ack) begin
      st_err_ff   <= link.err;
      st_bit_ff   <= link.bit_val;
      st_skip_ff  <= link.skip;
      st_rdata_ff <= link.rdata;
    end
  end

  assign link.req     = req_ff;
  assign link.op      = op_ff;
  assign link.addr    = addr_ff;
  assign link.bit_sel = bit_ff;
  assign link.wdata   = wdata_ff;

  // ==========================================================
  // interrupts: set wins over the read clear
  always_comb begin
    nxt_int_st = int_st_ff;
    // only bits the read reported are cleared; a set in the access cycle survives
    if (fin && !pwrite && paddr == `IOD_R_INT_ST) begin
      nxt_int_st = int_st_ff & ~prdata_ff[2:0];
    end
    if (link.ack || refuse) begin
      nxt_int_st[`IOD_INT_DONE] = 1'b1;
    end
    if ((link.ack && link.err) || refuse) begin
      nxt_int_st[`IOD_INT_ERR] = 1'b1;
    end
    if (link.ack && link.skip) begin
      nxt_int_st[`IOD_INT_SKIP] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_st_ff   <= 3'h0;
      int_mask_ff <= 3'h0;
      irq_ff      <= 1'b0;
    end else begin
      int_st_ff <= nxt_int_st;
      if (fin && pwrite && paddr == `IOD_R_INT_MASK) begin
        int_mask_ff <= pwdata[2:0];
      end
      irq_ff <= |(nxt_int_st & int_mask_ff);
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq     = irq_ff;

endmodule

/* tb/iod_properties.sv */
/*
  checker of the link between the core end and the i/o space decoder.
  assumes: the plain signals of the one link instance, all on pclk.
*/
`timescale 1ns/100ps
module iod_properties
  import iod_pkg::*;
(
  input logic       pclk,
  input logic       presetn,
  input logic       req,
  input iod_op_e    op,
  input logic [7:0] addr,
  input logic [2:0] bit_sel,
  input logic [7:0] wdata,
  input logic       ack,
  input logic [7:0] rdata,
  input logic       bit_val,
  input logic       skip,
  input logic       err
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========
  // sequences
  sequence s_bit_req;
    req && op inside {bit_set_op, bit_clear_op, skip_if_bit_set_op, skip_if_bit_clear_op};
  endsequence
  sequence s_rsvd_rd;
    req && op == memory_read_op && addr >= 8'hC7;
  endsequence
  sequence s_empty_ans;
    ack && err && rdata == 8'h00;
  endsequence

  // ==========
  // properties
  property p_ack_next;
    req |=> ack && !req;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after req");
  property p_err_ack;
    err |-> ack;
  endproperty
  a_err_ack: assert property (p_err_ack) else $error("err without ack");
  property p_bit_val;
    ack |-> bit_val == rdata[bit_sel];
  endproperty
  a_bit_val: assert property (p_bit_val) else $error("bit_val not selected bit");
  property p_skip_set;
    ack && op == skip_if_bit_set_op |-> skip == rdata[bit_sel];
  endproperty
  a_skip_set: assert property (p_skip_set) else $error("skip on set wrong");
  property p_skip_clr;
    ack && op == skip_if_bit_clear_op |-> skip == !rdata[bit_sel];
  endproperty
  a_skip_clr: assert property (p_skip_clr) else $error("skip on clear wrong");
  property p_port_range;
    req && op inside {port_in_op, port_out_op} |-> addr <= 8'h3F;
  endproperty
  a_port_range: assert property (p_port_range) else $error("port op out of range");
  property p_bit_range;
    s_bit_req |-> addr <= 8'h1F;
  endproperty
  a_bit_range: assert property (p_bit_range) else $error("bit op out of range");
  property p_no_rsvd_write;
    req && op == memory_write_op |-> addr >= 8'h20 && (addr < 8'h60 ||
      addr inside {[8'hB9:8'hBD], [8'hC0:8'hC2], [8'hC4:8'hC6]});
  endproperty
  a_no_rsvd_write: assert property (p_no_rsvd_write) else $error("reserved write");
  property p_rsvd_read;
    s_rsvd_rd |=> s_empty_ans;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved read not zero");
endmodule

/* tb/io_space_decoder_tb_top.sv */
/*
  self-checking bench of core end and decoder joined by the link.
  assumes: apb answers in a few cycles; design files compiled before.
*/
`timescale 1ns/100ps
module io_space_decoder_tb_top
  import iod_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  flag_set = 8'h00;
  logic        twi_set = 1'b0;
  logic        txc_set = 1'b0;
  logic [31:0] prdata, st;
  logic        pready, pslverr, irq, e;
  logic [7:0]  io_flags;
  logic [87:0] ext_view;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  // status masks: busy and err always, read fields and skip as the op gives them
  localparam logic [15:0] W = 16'h0003, R = 16'hFF07, S = 16'hFF0F;

  always #20 pclk = ~pclk;

  iod_if link_i ();
  iod_device iod_device_inst (.pclk(pclk), .presetn(presetn), .link(link_i),
    .flag_set(flag_set), .twi_int_set(twi_set), .serial_txc_set(txc_set),
    .io_flags(io_flags), .ext_view(ext_view));
  iod_core iod_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(link_i));
  iod_properties iod_properties_inst (.pclk(pclk), .presetn(presetn), .req(link_i.req),
    .op(link_i.op), .addr(link_i.addr), .bit_sel(link_i.bit_sel), .wdata(link_i.wdata),
    .ack(link_i.ack), .rdata(link_i.rdata), .bit_val(link_i.bit_val),
    .skip(link_i.skip), .err(link_i.err));

  // ==========
  // shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) n_mismatch++;
    st = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(st, x);
  endtask

  // one command, then poll status until idle and judge it
  task automatic run(input iod_op_e o, input logic [7:0] a, input logic [2:0] b,
                     input logic [7:0] d, input logic [15:0] m, input logic [15:0] x);
    int n;
    n = 0;
    apb(1'b1, 12'h000, {d, 5'h00, b, a, 4'h0, o});
    st = 32'h1;
    while (st[0] !== 1'b0 && n < 20) begin
      n++;
      apb(1'b0, 12'h004, 32'h0);
    end
    chk({16'h0, st[15:0] & m}, {16'h0, x});
  endtask

  task automatic pulse_events;
    @(posedge pclk);
    flag_set <= 8'hF0;
    twi_set <= 1'b1;
    txc_set <= 1'b1;
    @(posedge pclk);
    flag_set <= 8'h00;
    twi_set <= 1'b0;
    txc_set <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  // ==========
  // scenarios
  task automatic t_regs;
    rd(12'h008, 32'h0);
    rd(12'h00C, 32'h0);
    apb(1'b1, 12'h00C, 32'h5);
    rd(12'h00C, 32'h5);
    rd(12'h010, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 12'h00C, 32'h0);
  endtask

  task automatic t_irq;
    run(port_out_op, 8'h01, 3'h0, 8'h01, W, 16'h0000);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h00C, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    rd(12'h008, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h00C, 32'h2);
    run(port_in_op, 8'h40, 3'h0, 8'h00, W, 16'h0002);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    rd(12'h008, 32'h3);
    apb(1'b1, 12'h00C, 32'h0);
  endtask

  task automatic t_bits;
    run(port_out_op, 8'h10, 3'h0, 8'h81, W, 16'h0000);
    run(bit_set_op, 8'h10, 3'h3, 8'h00, W, 16'h0000);
    run(bit_clear_op, 8'h10, 3'h0, 8'h00, W, 16'h0000);
    run(port_in_op, 8'h10, 3'h3, 8'h00, R, 16'h8804);
    run(skip_if_bit_set_op, 8'h10, 3'h3, 8'h00, S, 16'h880C);
    run(skip_if_bit_clear_op, 8'h10, 3'h3, 8'h00, S, 16'h8804);
    run(skip_if_bit_clear_op, 8'h10, 3'h0, 8'h00, S, 16'h8808);
    run(bit_set_op, 8'h1F, 3'h7, 8'h00, W, 16'h0000);
    run(port_in_op, 8'h1F, 3'h7, 8'h00, R, 16'h8004);
    run(bit_set_op, 8'h20, 3'h1, 8'h00, W, 16'h0002);
    run(port_in_op, 8'h20, 3'h1, 8'h00, R, 16'h0000);
  endtask

  task automatic t_map;
    run(port_out_op, 8'h05, 3'h0, 8'hA5, W, 16'h0000);
    run(memory_read_op, 8'h25, 3'h0, 8'h00, R, 16'hA504);
    run(memory_write_op, 8'h5F, 3'h0, 8'h3C, W, 16'h0000);
    run(port_in_op, 8'h3F, 3'h2, 8'h00, R, 16'h3C04);
    run(memory_read_op, 8'h1F, 3'h0, 8'h00, W, 16'h0002);
  endtask

  // flags at io 0x16 and slots 0xBC/0xC0 share one event burst
  task automatic t_flags;
    run(memory_write_op, 8'hBC, 3'h0, 8'h0F, W, 16'h0000);
    pulse_events;
    chk({24'h0, io_flags}, 32'hF0);
    chk({24'h0, ext_view[31:24]}, 32'h85);
    chk({24'h0, ext_view[47:40]}, 32'h40);
    run(port_out_op, 8'h16, 3'h0, 8'h10, W, 16'h0000);
    chk({24'h0, io_flags}, 32'hE0);
    run(bit_clear_op, 8'h16, 3'h7, 8'h00, W, 16'h0000);
    chk({24'h0, io_flags}, 32'hE0);
    run(bit_set_op, 8'h16, 3'h6, 8'h00, W, 16'h0000);
    chk({24'h0, io_flags}, 32'hA0);
    run(memory_read_op, 8'h36, 3'h5, 8'h00, R, 16'hA004);
    run(memory_write_op, 8'hC0, 3'h0, 8'h00, W, 16'h0000);
    run(memory_read_op, 8'hC0, 3'h6, 8'h00, R, 16'h4004);
    run(memory_write_op, 8'hC0, 3'h0, 8'h40, W, 16'h0000);
    run(memory_read_op, 8'hC0, 3'h6, 8'h00, R, 16'h0000);
    run(memory_write_op, 8'hBC, 3'h0, 8'h85, W, 16'h0000);
    run(memory_read_op, 8'hBC, 3'h7, 8'h00, R, 16'h0500);
  endtask

  task automatic t_rsvd;
    run(memory_write_op, 8'hBD, 3'h0, 8'hFF, W, 16'h0000);
    run(memory_read_op, 8'hBD, 3'h0, 8'h00, R, 16'hFE00);
    run(memory_read_op, 8'hD0, 3'h0, 8'h00, R, 16'h0002);
    run(memory_write_op, 8'hC3, 3'h0, 8'hFF, W, 16'h0002);
    run(memory_read_op, 8'hC3, 3'h0, 8'h00, R, 16'h0002);
    run(memory_write_op, 8'h60, 3'h0, 8'hFF, W, 16'h0002);
  endtask

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========
  // main sequence and watchdog
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_irq;
    t_bits;
    t_map;
    t_flags;
    t_rsvd;
    final_report;
  end

  // whole run is a few hundred cycles; this cuts a hang
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    final_report;
  end
endmodule
